// ==== ecs_pkg.sv ====
package ecs_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [31:0] ADDR_REGION_BASE_CS0    = 32'h00FF0014;
    localparam logic [31:0] ADDR_REGION_BASE_CS1    = 32'h00FF0018;
    localparam logic [31:0] ADDR_REGION_BASE_CS2    = 32'h00FF001C;
    localparam logic [31:0] ADDR_REGION_SHAPE_CS0   = 32'h00FF0054;
    localparam logic [31:0] ADDR_REGION_SHAPE_CS1   = 32'h00FF0058;
    localparam logic [31:0] ADDR_REGION_SHAPE_CS2   = 32'h00FF005C;
    localparam logic [31:0] ADDR_CYCLE_TIMING_SET0  = 32'h00FF0094;
    localparam logic [31:0] ADDR_CYCLE_TIMING_SET1  = 32'h00FF0098;
    localparam logic [31:0] ADDR_CYCLE_TIMING_SET2  = 32'h00FF009C;
    localparam logic [31:0] ADDR_FLASH_WAKEUP_DELAY = 32'h00FF00A0;
    localparam logic [31:0] ADDR_BUS_WIDTH_CONTROL  = 32'h00FF00A4;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [31:0] RST_REGION_BASE_CS0    = 32'h00400000;
    localparam logic [31:0] RST_REGION_BASE_CS1    = 32'h00800000;
    localparam logic [31:0] RST_REGION_BASE_CS2    = 32'h01000000;
    localparam logic [31:0] RST_REGION_SHAPE_CS0   = 32'h00000028;
    localparam logic [31:0] RST_REGION_SHAPE_CS1   = 32'h00000128;
    localparam logic [31:0] RST_REGION_SHAPE_CS2   = 32'h00000229;
    localparam logic [31:0] RST_CYCLE_TIMING_SET0  = 32'h00020D45;
    localparam logic [31:0] RST_CYCLE_TIMING_SET1  = 32'h00120D45;
    localparam logic [31:0] RST_CYCLE_TIMING_SET2  = 32'h001A0D45;
    localparam logic [31:0] RST_FLASH_WAKEUP_DELAY = 32'h000000C8;
    localparam logic [31:0] RST_BUS_WIDTH_CONTROL  = 32'h00000401;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int          BASE_LSB        = 16;
    localparam int          WIDTH_CODE_LSB  = 7;
    localparam int          WIDTH_CODE_W    = 3;
    localparam logic [31:0] BASE_WMASK      = 32'hFFFF0000;
    localparam logic [31:0] SHAPE_WMASK     = 32'h000007FF;
    localparam logic [31:0] WIDTH_WMASK     = 32'h0000FF80;
    localparam logic [4:0]  SIZE_NONE       = 5'h00;
    localparam logic [4:0]  SIZE_MAX_LEGAL  = 5'h11;
    localparam int          SIZE_SHIFT_BASE = 15;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [2:0] WIDTH_16   = 3'h0;
    localparam logic [2:0] WIDTH_32   = 3'h1;
    localparam logic [2:0] WIDTH_8    = 3'h4;
    localparam logic [2:0] TYPE_RSVD  = 3'h0;
    localparam logic [2:0] TYPE_RAM   = 3'h1;
    localparam logic [2:0] TYPE_FLASH = 3'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef struct packed {
        logic [20:0] rsvd;
        logic [2:0]  tsel;
        logic [2:0]  mtype;
        logic [4:0]  size;
    } ecs_shape_t;

    typedef struct packed {
        logic [2:0]  width;
        logic [2:0]  mtype;
        logic [31:0] timing;
    } ecs_cs_info_t;

endpackage

// ==== ecs_top.sv ====
// Overview of operation
// - Three-bit width code per chip select.
// - Width control resets to 0000_0401h.
// - Only base bits 31:16 decode.
// - Base bits inside size are ignored.
// - Base registers reset to documented values.
// - Five-bit size code, zero none, reserved high.
// - Any chip select may share any set.
// - Shape registers reset to documented values.
// - Assert chip select inside mapped region.
// - Address passes out without relocation.
`timescale 1ns/100ps
`default_nettype none

module ecs_top #(
    parameter int NUM_CS = 3
) (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rstn_i,
    // AHB-Lite slave
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic      [31:0]          hrdata_o,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    // On-chip memory access
    input  wire logic                 acc_valid_i,
    input  wire logic [31:0]          acc_addr_i,
    // External bus side
    output logic      [31:0]          ext_addr_o,
    output logic      [NUM_CS-1:0]    device_select_n_o,
    output ecs_pkg::ecs_cs_info_t     cs_info_o
);

    // ************************************************************
    // Parameter check
    // ************************************************************
    if (NUM_CS != 3) begin : g_bad_cs
        $error("ecs_top supports exactly three chip selects.");
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    // Decode mask over address bits: ones where the base must match.
    function automatic logic [31:0] care_mask(input logic [4:0] size);
        logic [31:0] m;
        m = '0;
        for (int i = ecs_pkg::BASE_LSB; i < 32; i++) begin
            if (i >= ecs_pkg::SIZE_SHIFT_BASE + int'(size)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [31:0] wmask);
        return (old & ~wmask) | (wd & wmask);
    endfunction

    // Writable bits of the word at a byte address; unmapped words have none.
    function automatic logic [31:0] wmask_of(input logic [31:0] a);
        logic [31:0] m;
        m = 32'h00000000;
        if (a == ecs_pkg::ADDR_REGION_BASE_CS0 || a == ecs_pkg::ADDR_REGION_BASE_CS1 ||
            a == ecs_pkg::ADDR_REGION_BASE_CS2) begin
            m = ecs_pkg::BASE_WMASK;
        end
        if (a == ecs_pkg::ADDR_REGION_SHAPE_CS0 || a == ecs_pkg::ADDR_REGION_SHAPE_CS1 ||
            a == ecs_pkg::ADDR_REGION_SHAPE_CS2) begin
            m = ecs_pkg::SHAPE_WMASK;
        end
        if (a == ecs_pkg::ADDR_BUS_WIDTH_CONTROL) begin
            m = ecs_pkg::WIDTH_WMASK;
        end
        if (a == ecs_pkg::ADDR_CYCLE_TIMING_SET0 || a == ecs_pkg::ADDR_CYCLE_TIMING_SET1 ||
            a == ecs_pkg::ADDR_CYCLE_TIMING_SET2 || a == ecs_pkg::ADDR_FLASH_WAKEUP_DELAY) begin
            m = 32'hFFFFFFFF;
        end
        return m;
    endfunction

    // ************************************************************
    // AHB address phase capture
    // ************************************************************
    logic        wr_pend_q;
    logic [31:0] wr_addr_q;
    logic        take;

    assign take = hsel_i && hready_i && (htrans_i == ecs_pkg::HTRANS_NONSEQ || htrans_i == ecs_pkg::HTRANS_SEQ);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h00000000;
        end else begin
            wr_pend_q <= take && hwrite_i;
            if (take) begin
                wr_addr_q <= haddr_i;
            end
        end
    end

    // The slave never stalls once out of reset and never errors; unmapped words read zero.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            hreadyout_o <= 1'b0;
            hresp_o     <= ecs_pkg::HRESP_OKAY;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= ecs_pkg::HRESP_OKAY;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    logic [31:0] base_q   [NUM_CS];
    logic [31:0] shape_q  [NUM_CS];
    logic [31:0] timing_q [NUM_CS];
    logic [31:0] flash_delay_q;
    logic [31:0] width_ctl_q;
    logic [31:0] base_rst   [NUM_CS];
    logic [31:0] shape_rst  [NUM_CS];
    logic [31:0] timing_rst [NUM_CS];
    logic [31:0] base_addr  [NUM_CS];
    logic [31:0] shape_addr [NUM_CS];
    logic [31:0] timing_addr[NUM_CS];

    assign base_rst[0]   = ecs_pkg::RST_REGION_BASE_CS0;
    assign base_rst[1]   = ecs_pkg::RST_REGION_BASE_CS1;
    assign base_rst[2]   = ecs_pkg::RST_REGION_BASE_CS2;
    assign shape_rst[0]  = ecs_pkg::RST_REGION_SHAPE_CS0;
    assign shape_rst[1]  = ecs_pkg::RST_REGION_SHAPE_CS1;
    assign shape_rst[2]  = ecs_pkg::RST_REGION_SHAPE_CS2;
    assign timing_rst[0] = ecs_pkg::RST_CYCLE_TIMING_SET0;
    assign timing_rst[1] = ecs_pkg::RST_CYCLE_TIMING_SET1;
    assign timing_rst[2] = ecs_pkg::RST_CYCLE_TIMING_SET2;
    assign base_addr[0]   = ecs_pkg::ADDR_REGION_BASE_CS0;
    assign base_addr[1]   = ecs_pkg::ADDR_REGION_BASE_CS1;
    assign base_addr[2]   = ecs_pkg::ADDR_REGION_BASE_CS2;
    assign shape_addr[0]  = ecs_pkg::ADDR_REGION_SHAPE_CS0;
    assign shape_addr[1]  = ecs_pkg::ADDR_REGION_SHAPE_CS1;
    assign shape_addr[2]  = ecs_pkg::ADDR_REGION_SHAPE_CS2;
    assign timing_addr[0] = ecs_pkg::ADDR_CYCLE_TIMING_SET0;
    assign timing_addr[1] = ecs_pkg::ADDR_CYCLE_TIMING_SET1;
    assign timing_addr[2] = ecs_pkg::ADDR_CYCLE_TIMING_SET2;

    // Rewriting these while accesses run is legal but may glitch a
    // chip select choice for the one access in flight.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_CS; i++) begin
                base_q[i]   <= base_rst[i];
                shape_q[i]  <= shape_rst[i];
                timing_q[i] <= timing_rst[i];
            end
        end else if (wr_pend_q) begin
            for (int i = 0; i < NUM_CS; i++) begin
                if (wr_addr_q == base_addr[i]) begin
                    base_q[i] <= merge(base_q[i], hwdata_i, ecs_pkg::BASE_WMASK);
                end
                if (wr_addr_q == shape_addr[i]) begin
                    shape_q[i] <= merge(shape_q[i], hwdata_i, ecs_pkg::SHAPE_WMASK);
                end
                if (wr_addr_q == timing_addr[i]) begin
                    timing_q[i] <= hwdata_i;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            flash_delay_q <= ecs_pkg::RST_FLASH_WAKEUP_DELAY;
        end else if (wr_pend_q && wr_addr_q == ecs_pkg::ADDR_FLASH_WAKEUP_DELAY) begin
            flash_delay_q <= hwdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            width_ctl_q <= ecs_pkg::RST_BUS_WIDTH_CONTROL;
        end else if (wr_pend_q && wr_addr_q == ecs_pkg::ADDR_BUS_WIDTH_CONTROL) begin
            width_ctl_q <= merge(width_ctl_q, hwdata_i, ecs_pkg::WIDTH_WMASK);
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [31:0] rd_word;
    logic [31:0] rd_fwd;

    always_comb begin
        rd_word = 32'h00000000;
        for (int i = 0; i < NUM_CS; i++) begin
            if (haddr_i == base_addr[i]) begin
                rd_word = base_q[i];
            end
            if (haddr_i == shape_addr[i]) begin
                rd_word = shape_q[i];
            end
            if (haddr_i == timing_addr[i]) begin
                rd_word = timing_q[i];
            end
        end
        if (haddr_i == ecs_pkg::ADDR_FLASH_WAKEUP_DELAY) begin
            rd_word = flash_delay_q;
        end
        if (haddr_i == ecs_pkg::ADDR_BUS_WIDTH_CONTROL) begin
            rd_word = width_ctl_q;
        end
    end

    // A write lands only at the end of its data phase, so a read of the same
    // word taken in that cycle would see the old value without this path.
    always_comb begin
        rd_fwd = rd_word;
        if (wr_pend_q && wr_addr_q == haddr_i) begin
            rd_fwd = merge(rd_word, hwdata_i, wmask_of(haddr_i));
        end
    end

    // Read data is loaded at the edge that takes the address phase, so it
    // stands through the whole data phase and is zero otherwise.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            hrdata_o <= 32'h00000000;
        end else if (take && !hwrite_i) begin
            hrdata_o <= rd_fwd;
        end else begin
            hrdata_o <= 32'h00000000;
        end
    end

    // ************************************************************
    // Region decode
    // ************************************************************
    logic [NUM_CS-1:0] hit;
    logic [NUM_CS-1:0] one_hot;
    logic [1:0]        win_idx;
    ecs_pkg::ecs_shape_t shp [NUM_CS];

    always_comb begin
        for (int i = 0; i < NUM_CS; i++) begin
            shp[i] = ecs_pkg::ecs_shape_t'(shape_q[i]);
            hit[i] = 1'b0;
            // size zero and reserved codes map nothing
            // compare only bits above the size
            if (shp[i].size != ecs_pkg::SIZE_NONE && shp[i].size <= ecs_pkg::SIZE_MAX_LEGAL) begin
                // mask base bits inside the size
                hit[i] = ((acc_addr_i ^ base_q[i]) & care_mask(shp[i].size)) == 32'h00000000;
            end
        end
    end

    // Overlapping regions would drive two selects at once; the lowest
    // index wins so the external bus never sees contention.
    always_comb begin
        one_hot = '0;
        win_idx = 2'h0;
        for (int i = NUM_CS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                one_hot = '0;
                one_hot[i] = 1'b1;
                win_idx = 2'(i);
            end
        end
    end

    // drive selects for a mapped access
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            device_select_n_o <= '1;
        end else if (acc_valid_i) begin
            device_select_n_o <= ~one_hot;
        end else begin
            device_select_n_o <= '1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ext_addr_o <= 32'h00000000;
        end else if (acc_valid_i) begin
            ext_addr_o <= acc_addr_i;
        end
    end

    // ************************************************************
    // Per-access device attributes
    // ************************************************************
    logic [ecs_pkg::WIDTH_CODE_W-1:0] width_code [NUM_CS];
    logic [31:0]                      sel_timing;
    logic [2:0]                       tsel_w;

    // one width code per chip select
    always_comb begin
        for (int i = 0; i < NUM_CS; i++) begin
            width_code[i] = width_ctl_q[ecs_pkg::WIDTH_CODE_LSB + ecs_pkg::WIDTH_CODE_W * i +:
                                        ecs_pkg::WIDTH_CODE_W];
        end
    end

    // any select may share any set
    always_comb begin
        tsel_w = shp[win_idx].tsel;
        case (tsel_w)
            3'h0: sel_timing = timing_q[0];
            3'h1: sel_timing = timing_q[1];
            3'h2: sel_timing = timing_q[2];
            default: sel_timing = timing_q[0];
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            cs_info_o <= '0;
        end else if (acc_valid_i && hit != '0) begin
            cs_info_o.width  <= width_code[win_idx];
            cs_info_o.mtype  <= shp[win_idx].mtype;
            cs_info_o.timing <= sel_timing;
        end
    end

endmodule

`default_nettype wire

// ==== ecs_top_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module ecs_top_asserts #(
    parameter int NUM_CS = 3
) (
    // Clock and reset
    input wire logic                  ref_clk_i,
    input wire logic                  rstn_i,
    // Register bus
    input wire logic                  hsel_i,
    input wire logic [31:0]           haddr_i,
    input wire logic [1:0]            htrans_i,
    input wire logic                  hwrite_i,
    input wire logic [2:0]            hsize_i,
    input wire logic [31:0]           hwdata_i,
    input wire logic                  hready_i,
    input wire logic [31:0]           hrdata_o,
    input wire logic                  hreadyout_o,
    input wire logic                  hresp_o,
    // Access decode
    input wire logic                  acc_valid_i,
    input wire logic [31:0]           acc_addr_i,
    input wire logic [31:0]           ext_addr_o,
    input wire logic [NUM_CS-1:0]     device_select_n_o,
    input wire ecs_pkg::ecs_cs_info_t cs_info_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    a_sel_onehot: assert property ($onehot0(~device_select_n_o))
        else $error("more than one chip select active");
    a_sel_cause: assert property (!(&device_select_n_o) |-> $past(acc_valid_i))
        else $error("chip select active without an access");
    a_idle_desel: assert property (!acc_valid_i |=> &device_select_n_o)
        else $error("chip select active after access ended");
    a_addr_pass: assert property (acc_valid_i |=> ext_addr_o == $past(acc_addr_i))
        else $error("external address differs from access address");
    a_addr_hold: assert property (!acc_valid_i |=> $stable(ext_addr_o))
        else $error("external address moved without an access");
    a_info_hold: assert property (&device_select_n_o |-> $stable(cs_info_o))
        else $error("device info changed without a hit");
    a_ready_up: assert property ($past(rstn_i) |-> hreadyout_o)
        else $error("bus ready low outside reset");
    a_resp_okay: assert property (hresp_o == 1'h0)
        else $error("bus response not okay");
    a_rdata_idle: assert property (!$past(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |-> hrdata_o == 32'h0)
        else $error("read data outside a read data phase");
endmodule

bind ecs_top ecs_top_asserts #(.NUM_CS(NUM_CS)) chk_u (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i),
    .ext_addr_o(ext_addr_o), .device_select_n_o(device_select_n_o), .cs_info_o(cs_info_o)
);
`default_nettype wire

// ==== ecs_ext_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ecs_ext_mem_model (
    // Clock
    input  wire logic        ref_clk_i,
    // Lines from the unit
    input  wire logic [31:0] ext_addr_i,
    input  wire logic [2:0]  device_select_n_i,
    // Last access seen
    output logic      [1:0]  seen_cs_o,
    output logic      [31:0] seen_addr_o
);
    always @(posedge ref_clk_i) begin
        for (int i = 0; i < 3; i++) begin
            if (device_select_n_i[i] == 1'h0) begin
                seen_cs_o <= 2'(i);
                seen_addr_o <= ext_addr_i;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic                  clk = 1'h0;
    logic                  rst_n = 1'h0;
    logic                  hsel = 1'h0;
    logic [31:0]           haddr = 32'h0;
    logic [1:0]            htrans = 2'h0;
    logic                  hwrite = 1'h0;
    logic [31:0]           hwdata = 32'h0;
    logic                  acc_valid = 1'h0;
    logic [31:0]           acc_addr = 32'h0;
    wire logic             hready;
    logic [31:0]           hrdata;
    logic                  hresp;
    logic [31:0]           ext_addr;
    logic [2:0]            dsel_n;
    ecs_pkg::ecs_cs_info_t info;
    ecs_pkg::ecs_cs_info_t last = '0;
    logic [1:0]            seen_cs;
    logic [31:0]           seen_addr;
    int                    fails = 0;
    int                    comparisons = 0;

    always #10 clk = ~clk;

    ecs_top dut_u (
        .ref_clk_i(clk), .rstn_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .acc_valid_i(acc_valid), .acc_addr_i(acc_addr), .ext_addr_o(ext_addr),
        .device_select_n_o(dsel_n), .cs_info_o(info)
    );
    ecs_ext_mem_model model_u (
        .ref_clk_i(clk), .ext_addr_i(ext_addr), .device_select_n_i(dsel_n), .seen_cs_o(seen_cs),
        .seen_addr_o(seen_addr)
    );

    // ****************
    // Shared tasks
    // ****************
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The read word stands only in the data phase, so it is taken at the edge that closes it.
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= ecs_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'h1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'h1, a, d, r);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'h0, a, 32'h0, r);
        check(64'(r), 64'(e));
        check(64'(hresp), 64'(ecs_pkg::HRESP_OKAY));
    endtask

    function automatic ecs_pkg::ecs_cs_info_t mk(input logic [2:0] w, input logic [2:0] t, input logic [31:0] tm);
        return {w, t, tm};
    endfunction

    // An index of 3 means no region should hit; the info output must then hold.
    task automatic acc(input logic [31:0] a, input int idx, input ecs_pkg::ecs_cs_info_t exp);
        logic [2:0] sel;
        sel = ~(3'h1 << idx);
        @(posedge clk);
        acc_valid <= 1'h1;
        acc_addr <= a;
        @(posedge clk);
        acc_valid <= 1'h0;
        #1;
        if (idx < 3) last = exp;
        check(64'(dsel_n), 64'(sel));
        check(64'(ext_addr), 64'(a));
        check(64'(info), 64'(last));
        @(posedge clk);
        #1;
        check(64'(dsel_n), 64'h7);
        if (idx < 3) check(64'({seen_cs, seen_addr}), 64'({2'(idx), a}));
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        rchk(ecs_pkg::ADDR_BUS_WIDTH_CONTROL, 32'h00000401);
        rchk(ecs_pkg::ADDR_REGION_BASE_CS0, 32'h00400000);
        rchk(ecs_pkg::ADDR_REGION_BASE_CS1, 32'h00800000);
        rchk(ecs_pkg::ADDR_REGION_BASE_CS2, 32'h01000000);
        rchk(ecs_pkg::ADDR_REGION_SHAPE_CS0, 32'h00000028);
        rchk(ecs_pkg::ADDR_REGION_SHAPE_CS1, 32'h00000128);
        rchk(ecs_pkg::ADDR_REGION_SHAPE_CS2, 32'h00000229);
    endtask

    task automatic t_decode();
        acc(32'h00400010, 0, mk(ecs_pkg::WIDTH_16, ecs_pkg::TYPE_RAM, ecs_pkg::RST_CYCLE_TIMING_SET0));
        acc(32'h00200000, 0, mk(ecs_pkg::WIDTH_16, ecs_pkg::TYPE_RAM, ecs_pkg::RST_CYCLE_TIMING_SET0));
        acc(32'h00800004, 1, mk(ecs_pkg::WIDTH_32, ecs_pkg::TYPE_RAM, ecs_pkg::RST_CYCLE_TIMING_SET1));
        acc(32'h01FFFFFC, 2, mk(ecs_pkg::WIDTH_16, ecs_pkg::TYPE_RAM, ecs_pkg::RST_CYCLE_TIMING_SET2));
        acc(32'h02000000, 3, '0);
    endtask

    task automatic t_bits();
        wr(ecs_pkg::ADDR_REGION_BASE_CS0, 32'hFFFFFFFF);
        rchk(ecs_pkg::ADDR_REGION_BASE_CS0, 32'hFFFF0000);
        wr(ecs_pkg::ADDR_REGION_SHAPE_CS0, 32'hFFFFFFFF);
        rchk(ecs_pkg::ADDR_REGION_SHAPE_CS0, 32'h000007FF);
        wr(ecs_pkg::ADDR_BUS_WIDTH_CONTROL, 32'hFFFFFFFF);
        rchk(ecs_pkg::ADDR_BUS_WIDTH_CONTROL, 32'h0000FF81);
        wr(ecs_pkg::ADDR_CYCLE_TIMING_SET0, 32'hA5A5A5A5);
        rchk(ecs_pkg::ADDR_CYCLE_TIMING_SET0, 32'hA5A5A5A5);
        wr(32'h00FF0000, 32'hFFFFFFFF);
        rchk(32'h00FF0000, 32'h0);
        acc(32'hFFFF0000, 3, '0);
        wr(ecs_pkg::ADDR_REGION_BASE_CS0, 32'h00400000);
        wr(ecs_pkg::ADDR_BUS_WIDTH_CONTROL, 32'h00000401);
    endtask

    task automatic t_sizes();
        logic [4:0]  code [6] = '{5'h01, 5'h01, 5'h00, 5'h12, 5'h11, 5'h10};
        logic [31:0] ad [6] = '{32'h0040FFFC, 32'h00410000, 32'h00400000, 32'h00400000, 32'h02000000, 32'h80000000};
        int          idx [6] = '{0, 3, 3, 3, 0, 3};
        for (int i = 0; i < 6; i++) begin
            wr(ecs_pkg::ADDR_REGION_SHAPE_CS0, {24'h0, 3'h1, code[i]});
            acc(ad[i], idx[i], mk(ecs_pkg::WIDTH_16, ecs_pkg::TYPE_RAM, 32'hA5A5A5A5));
        end
    endtask

    task automatic t_share();
        wr(ecs_pkg::ADDR_BUS_WIDTH_CONTROL, 32'h00003000);
        wr(ecs_pkg::ADDR_REGION_SHAPE_CS1, 32'h00000048);
        wr(ecs_pkg::ADDR_REGION_SHAPE_CS2, 32'h00000029);
        wr(ecs_pkg::ADDR_REGION_SHAPE_CS0, 32'h00000228);
        acc(32'h00800000, 1, mk(ecs_pkg::WIDTH_8, ecs_pkg::TYPE_FLASH, 32'hA5A5A5A5));
        acc(32'h01000000, 2, mk(ecs_pkg::WIDTH_32, ecs_pkg::TYPE_RAM, 32'hA5A5A5A5));
        acc(32'h00000000, 0, mk(ecs_pkg::WIDTH_16, ecs_pkg::TYPE_RAM, ecs_pkg::RST_CYCLE_TIMING_SET2));
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_decode();
        t_bits();
        t_sizes();
        t_share();
        final_report();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
